/* design/mci_consts.vh */
// Constants for the meter control inputs and error display block
`ifndef MCI_CONSTS_VH
`define MCI_CONSTS_VH

// AXI4-Lite register byte offsets
`define MCI_OFF_CTRL      8'h00
`define MCI_OFF_STATUS    8'h04
`define MCI_OFF_READING   8'h08
`define MCI_OFF_DISPLAY   8'h0c
`define MCI_OFF_TARE      8'h10
`define MCI_OFF_PEAK      8'h14
`define MCI_OFF_VALLEY    8'h18
`define MCI_OFF_SETPT     8'h1c
`define MCI_OFF_ERRIN     8'h20
`define MCI_OFF_EVENT     8'h24

// Control register fields
`define MCI_CTRL_RST_SCOPE   0
`define MCI_CTRL_PRINT_EN    1
`define MCI_CTRL_ALC_EN      2
`define MCI_CTRL_MENU_REQ    3
`define MCI_CTRL_CFG_EXIT    4
`define MCI_CTRL_RESET       8'h00

// Error input register fields (conditions from the measurement side)
`define MCI_ERR_OVLD      0
`define MCI_ERR_OPEN      1
`define MCI_ERR_NOPEN     2
`define MCI_ERR_IOVSC     3
`define MCI_ERR_ROVSC     4
`define MCI_ERR_CBOVF     5
`define MCI_ERR_UOMOVF    6
`define MCI_ERR_OFSOVF    7
`define MCI_ERR_SPOVF     8
`define MCI_ERR_STORED    9
`define MCI_ERR_NOSTOR    10
`define MCI_ERR_OPEN_EN   11

// Display message codes
`define MCI_MSG_READING   4'h0
`define MCI_MSG_NINES     4'h1
`define MCI_MSG_ERR01     4'h2
`define MCI_MSG_ERR02     4'h3
`define MCI_MSG_STORED    4'h4
`define MCI_MSG_NOSTOR    4'h5
`define MCI_MSG_OVLD      4'h6
`define MCI_MSG_POPEN     4'h7
`define MCI_MSG_NOPEN     4'h8
`define MCI_MSG_IOVSC     4'h9
`define MCI_MSG_ROVSC     4'ha
`define MCI_MSG_CBOVF     4'hb
`define MCI_MSG_UOMOVF    4'hc
`define MCI_MSG_HRESET    4'hd

// Display limits, 24-bit two's complement counts
`define MCI_DISP_MAX      24'h0f423f
`define MCI_DISP_MIN      24'hfe7961

// Timing
`define MCI_CLK_NS        8
`define MCI_DEB_MS        10
`define MCI_DEB_CYC       ((`MCI_DEB_MS * 1000000) / `MCI_CLK_NS)
`define MCI_MSG_MS        1000
`define MCI_MSG_CYC       ((`MCI_MSG_MS * 1000000) / `MCI_CLK_NS)
`define MCI_FLASH_MS      250
`define MCI_FLASH_CYC     ((`MCI_FLASH_MS * 1000000) / `MCI_CLK_NS)

`endif

/* design/mci_debounce.v */
// Synchroniser and debouncer for one active-low contact input
`timescale 1ns/10ps
module mci_debounce #(
  parameter DEB_CYC = 1250000
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin_n,
  output reg  level,
  output reg  pulse
);

  reg        s1_reg;
  reg        s2_reg;
  reg [20:0] cnt_reg;

  // Closed contact pulls the line low; level is high while closed
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      cnt_reg <= 21'h000000;
      level   <= 1'b0;
      pulse   <= 1'b0;
    end else begin
      s1_reg <= ~pin_n;
      s2_reg <= s1_reg;
      pulse  <= 1'b0;
      if (s2_reg == level) begin
        cnt_reg <= 21'h000000;
      end else if (cnt_reg >= DEB_CYC[20:0] - 21'h000001) begin
        cnt_reg <= 21'h000000;
        level   <= s2_reg;
        pulse   <= s2_reg;
      end else begin
        cnt_reg <= cnt_reg + 21'h000001;
      end
    end
  end

endmodule // mci_debounce

/* design/mci_meter_ctrl.v */
// Meter control inputs, setpoint drivers and error display selection
//
// Overview of operation
// [RULE1] Tare closure captures present reading as zero reference.
// [RULE2] Peak input closed shows stored highest reading, flashing.
// [RULE3] Valley input closed shows stored lowest reading, flashing.
// [RULE4] External reset: scope 0 hard reset with message; 1 clears peak/valley.
// [RULE5] Hold freezes display; tracking and outputs keep updating.
// [RULE6] Lockout blocks configuration changes and non-volatile writes.
// [RULE7] Lockout in run mode blocks menu entry into setup.
// [RULE8] Print input with print option set starts a serial printout.
// [RULE9] Print input with alarm-latch option set clears alarm latches.
// [RULE10] Auxiliary serial lines use RS-232 async framing at 5 V. This block has no serial lines; it only pulses print_start.
// [RULE11] Four setpoint outputs, each on while its condition holds; latched ones (reset default) stay on until RULE9 or a hard reset clears them.
// [RULE12] Value outside display range flashes all nines.
// [RULE13] Offset overflow flashes first error code.
// [RULE14] Setpoint overflow flashes second error briefly, then run mode.
// [RULE15] Confirmed change flashes stored/not-stored briefly then advances.
// [RULE16] Input beyond range flashes positive overload message.
// [RULE17] Open sensor with detection enabled flashes positive open.
// [RULE18] Below range with detection enabled flashes negative open.
// [RULE19] Input scale/offset overflow flashes input-overscale message.
// [RULE20] Reading scale/offset overflow flashes reading-overscale.
// [RULE21] Count-by rounding overflow flashes count-by overflow message.
// [RULE22] Unit character overflow flashes unit-of-measure overflow.
// [RULE23] Contact inputs are synchronised and debounced before use.
`timescale 1ns/10ps
`include "mci_consts.vh"
module mci_meter_ctrl #(
  parameter DEB_CYC   = `MCI_DEB_CYC,
  parameter MSG_CYC   = `MCI_MSG_CYC,
  parameter FLASH_CYC = `MCI_FLASH_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  // Rear connector contacts, low while closed
  input  wire        tare_n,
  input  wire        peak_sel_n,
  input  wire        valley_sel_n,
  input  wire        ext_reset_n,
  input  wire        hold_n,
  input  wire        lockout_n,
  input  wire        print_reset_n,
  // Live reading from the measurement side
  input  wire [23:0] reading,
  input  wire        reading_valid,
  // Setpoint drivers (open collector: asserted high turns transistor on)
  output reg         setpoint_out_one,
  output reg         setpoint_out_two,
  output reg         alarm_out_one,
  output reg         alarm_out_two,
  output reg  [23:0] display_value,
  output reg  [3:0]  display_msg,
  output reg         display_blank,
  output reg         print_start,
  output reg         hard_reset_req,
  output reg         nv_write_en,
  output reg         setup_mode,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------
  wire [6:0] pins_n = {print_reset_n, lockout_n, hold_n, ext_reset_n,
                       valley_sel_n, peak_sel_n, tare_n};
  wire [6:0] lvl;
  wire [6:0] pls;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_deb
      mci_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_n   (pins_n[gi]),
        .level   (lvl[gi]),
        .pulse   (pls[gi])
      ); // RULE23
    end
  endgenerate

  wire tare_p   = pls[0];
  wire peak_l   = lvl[1];
  wire valley_l = lvl[2];
  wire xrst_p   = pls[3];
  wire hold_l   = lvl[4];
  wire lock_l   = lvl[5];
  wire print_p  = pls[6];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]  ctrl_reg;
  reg  [23:0] tare_reg;
  reg  [23:0] peak_reg;
  reg  [23:0] valley_reg;
  reg         pv_valid_reg;
  reg  [23:0] sp_reg [0:3];
  reg  [11:0] err_reg;
  reg  [3:0]  latch_reg;
  reg  [3:0]  sp_mode_reg;
  reg  [3:0]  event_reg;
  reg  [3:0]  brief_msg_reg;
  reg  [26:0] brief_cnt_reg;
  reg  [24:0] flash_cnt_reg;
  reg         flash_ph_reg;

  wire [23:0] rel = reading - tare_reg;
  wire        rst_scope = ctrl_reg[`MCI_CTRL_RST_SCOPE];

  function out_of_range;
    input [23:0] v;
    begin
      out_of_range = ($signed(v) > $signed(`MCI_DISP_MAX)) ||
                     ($signed(v) < $signed(`MCI_DISP_MIN));
    end
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  wire       wr_go = aw_held && w_held && !s_axi_bvalid;
  wire       do_cfg = wr_go && !lock_l; // RULE6
  wire       do_write = wr_go && ((aw_addr == `MCI_OFF_CTRL) ||
                                  (aw_addr == `MCI_OFF_SETPT) ||
                                  (aw_addr == `MCI_OFF_ERRIN));
  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Locked writes other than ERRIN, and writes outside CTRL/SETPT/ERRIN, are answered with SLVERR
        s_axi_bresp  <= (do_write && !(lock_l && aw_addr !=
                         `MCI_OFF_ERRIN)) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'b00;
      case (s_axi_araddr)
        `MCI_OFF_CTRL:    s_axi_rdata <= {24'h000000, ctrl_reg};
        `MCI_OFF_STATUS:  s_axi_rdata <= {19'h00000, latch_reg,
                                          1'b0, setup_mode, lvl};
        `MCI_OFF_READING: s_axi_rdata <= {8'h00, rel};
        `MCI_OFF_DISPLAY: s_axi_rdata <= {4'h0, display_msg, display_value};
        `MCI_OFF_TARE:    s_axi_rdata <= {8'h00, tare_reg};
        `MCI_OFF_PEAK:    s_axi_rdata <= {8'h00, peak_reg};
        `MCI_OFF_VALLEY:  s_axi_rdata <= {8'h00, valley_reg};
        `MCI_OFF_SETPT:   s_axi_rdata <= {8'h00, sp_reg[0]};
        `MCI_OFF_ERRIN:   s_axi_rdata <= {20'h00000, err_reg};
        `MCI_OFF_EVENT:   s_axi_rdata <= {28'h0000000, event_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control, tare, peak/valley and setpoints
  // ---------------------------------------------------------------
  // SETPT write: bits 25:24 pick the setpoint, bit 27 latches it
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg       <= `MCI_CTRL_RESET;
      tare_reg       <= 24'h000000;
      peak_reg       <= 24'h000000;
      valley_reg     <= 24'h000000;
      pv_valid_reg   <= 1'b0;
      err_reg        <= 12'h000;
      latch_reg      <= 4'h0;
      sp_mode_reg    <= 4'h0;
      event_reg      <= 4'h0;
      setup_mode     <= 1'b0;
      hard_reset_req <= 1'b0;
      print_start    <= 1'b0;
      nv_write_en    <= 1'b0;
      for (i = 0; i < 4; i = i + 1) sp_reg[i] <= 24'h000000;
    end else begin
      hard_reset_req <= 1'b0;
      print_start    <= 1'b0;
      nv_write_en    <= 1'b0;
      if (wr_go && aw_addr == `MCI_OFF_EVENT)
        event_reg <= event_reg & ~w_data[3:0];
      if (tare_p && reading_valid)
        tare_reg <= reading; // RULE1
      // Tracking continues even while the display is held
      if (reading_valid) begin
        if (!pv_valid_reg || $signed(rel) > $signed(peak_reg))
          peak_reg <= rel; // RULE5
        if (!pv_valid_reg || $signed(rel) < $signed(valley_reg))
          valley_reg <= rel;
        pv_valid_reg <= 1'b1;
      end
      if (xrst_p) begin
        if (rst_scope) begin
          pv_valid_reg <= 1'b0; // RULE4
          peak_reg     <= 24'h000000;
          valley_reg   <= 24'h000000;
        end else begin
          hard_reset_req <= 1'b1; // RULE4
          tare_reg       <= 24'h000000;
          pv_valid_reg   <= 1'b0;
          latch_reg      <= 4'h0;
          setup_mode     <= 1'b0;
          event_reg[0]   <= 1'b1;
        end
      end
      if (print_p && ctrl_reg[`MCI_CTRL_PRINT_EN]) begin
        print_start  <= 1'b1; // RULE8
        event_reg[1] <= 1'b1;
      end
      if (print_p && ctrl_reg[`MCI_CTRL_ALC_EN])
        latch_reg <= 4'h0; // RULE9
      for (i = 0; i < 4; i = i + 1)
        if (!sp_mode_reg[i] && reading_valid &&
            $signed(rel) > $signed(sp_reg[i]))
          latch_reg[i] <= 1'b1; // RULE11
      if (wr_go && aw_addr == `MCI_OFF_ERRIN)
        err_reg <= w_data[11:0];
      if (do_cfg && aw_addr == `MCI_OFF_CTRL) begin
        ctrl_reg    <= {5'h00, w_data[2:0]}; // RULE6
        nv_write_en <= 1'b1;
        if (w_data[`MCI_CTRL_MENU_REQ] && !setup_mode)
          setup_mode <= 1'b1; // RULE7
        if (w_data[`MCI_CTRL_CFG_EXIT])
          setup_mode <= 1'b0;
      end
      if (do_cfg && aw_addr == `MCI_OFF_SETPT) begin
        sp_reg[w_data[25:24]]      <= w_data[23:0];
        sp_mode_reg[w_data[25:24]] <= ~w_data[27];
        nv_write_en                <= 1'b1;
      end
      if (err_reg[`MCI_ERR_SPOVF])
        setup_mode <= 1'b0; // RULE14
    end
  end

  // ---------------------------------------------------------------
  // Setpoint drivers
  // ---------------------------------------------------------------
  function sp_active;
    input [23:0] v;
    input [23:0] sp;
    input        latched;
    input        mode;
    begin
      sp_active = mode ? ($signed(v) > $signed(sp)) : latched;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      setpoint_out_one <= 1'b0;
      setpoint_out_two <= 1'b0;
      alarm_out_one    <= 1'b0;
      alarm_out_two    <= 1'b0;
    end else begin
      setpoint_out_one <= sp_active(rel, sp_reg[0], latch_reg[0],
                                    sp_mode_reg[0]); // RULE11
      setpoint_out_two <= sp_active(rel, sp_reg[1], latch_reg[1],
                                    sp_mode_reg[1]);
      alarm_out_one    <= sp_active(rel, sp_reg[2], latch_reg[2],
                                    sp_mode_reg[2]);
      alarm_out_two    <= sp_active(rel, sp_reg[3], latch_reg[3],
                                    sp_mode_reg[3]);
    end
  end

  // ---------------------------------------------------------------
  // Brief messages and flash timing
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      brief_msg_reg <= `MCI_MSG_READING;
      brief_cnt_reg <= 27'h0000000;
      flash_cnt_reg <= 25'h0000000;
      flash_ph_reg  <= 1'b0;
    end else begin
      if (flash_cnt_reg >= FLASH_CYC[24:0] - 25'h0000001) begin
        flash_cnt_reg <= 25'h0000000;
        flash_ph_reg  <= ~flash_ph_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 25'h0000001;
      end
      if (xrst_p && !rst_scope) begin
        brief_msg_reg <= `MCI_MSG_HRESET; // RULE4
        brief_cnt_reg <= MSG_CYC[26:0];
      end else if (err_reg[`MCI_ERR_SPOVF]) begin
        brief_msg_reg <= `MCI_MSG_ERR02; // RULE14
        brief_cnt_reg <= MSG_CYC[26:0];
      end else if (err_reg[`MCI_ERR_STORED] ||
                   err_reg[`MCI_ERR_NOSTOR]) begin
        brief_msg_reg <= (err_reg[`MCI_ERR_STORED] && !lock_l) ?
                         `MCI_MSG_STORED : `MCI_MSG_NOSTOR; // RULE15
        brief_cnt_reg <= MSG_CYC[26:0];
      end else if (brief_cnt_reg != 27'h0000000) begin
        brief_cnt_reg <= brief_cnt_reg - 27'h0000001;
      end else begin
        brief_msg_reg <= `MCI_MSG_READING;
      end
    end
  end

  // ---------------------------------------------------------------
  // Display selection
  // ---------------------------------------------------------------
  reg [3:0]  msg_next;
  reg [23:0] val_next;
  reg        flash_next;
  wire       open_en = err_reg[`MCI_ERR_OPEN_EN];

  always @* begin
    val_next   = hold_l ? display_value : rel; // RULE5
    flash_next = 1'b0;
    msg_next   = `MCI_MSG_READING;
    if (peak_l) begin
      val_next   = peak_reg; // RULE2
      flash_next = 1'b1;
    end else if (valley_l) begin
      val_next   = valley_reg; // RULE3
      flash_next = 1'b1;
    end
    if (brief_cnt_reg != 27'h0000000) begin
      msg_next   = brief_msg_reg; // RULE15
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_OFSOVF]) begin
      msg_next   = `MCI_MSG_ERR01; // RULE13
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_OVLD]) begin
      msg_next   = `MCI_MSG_OVLD; // RULE16
      flash_next = 1'b1;
    end else if (open_en && err_reg[`MCI_ERR_OPEN]) begin
      msg_next   = `MCI_MSG_POPEN; // RULE17
      flash_next = 1'b1;
    end else if (open_en && err_reg[`MCI_ERR_NOPEN]) begin
      msg_next   = `MCI_MSG_NOPEN; // RULE18
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_IOVSC]) begin
      msg_next   = `MCI_MSG_IOVSC; // RULE19
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_ROVSC]) begin
      msg_next   = `MCI_MSG_ROVSC; // RULE20
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_CBOVF]) begin
      msg_next   = `MCI_MSG_CBOVF; // RULE21
      flash_next = 1'b1;
    end else if (err_reg[`MCI_ERR_UOMOVF]) begin
      msg_next   = `MCI_MSG_UOMOVF; // RULE22
      flash_next = 1'b1;
    end else if (out_of_range(val_next)) begin
      msg_next   = `MCI_MSG_NINES; // RULE12
      val_next   = `MCI_DISP_MAX;
      flash_next = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      display_value <= 24'h000000;
      display_msg   <= `MCI_MSG_READING;
      display_blank <= 1'b0;
    end else begin
      display_value <= val_next;
      display_msg   <= msg_next;
      display_blank <= flash_next & flash_ph_reg;
    end
  end

endmodule // mci_meter_ctrl

/* tb/mci_meter_ctrl_assertions.sv */
// Port-level checks for the meter control block
`timescale 1ns/10ps
module mci_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        lockout_n,
  input wire        hold_n,
  input wire        peak_sel_n,
  input wire        valley_sel_n,
  input wire        ext_reset_n,
  input wire        print_start,
  input wire        hard_reset_req,
  input wire        nv_write_en,
  input wire        setup_mode,
  input wire [23:0] display_value,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  // ----------------------------------------
  // Closure age counters
  // ----------------------------------------
  // Saturate so long closures never wrap to zero
  reg [4:0] lock_cnt;
  reg [4:0] hold_cnt;
  always @(posedge aclk) begin
    if (!aresetn || lockout_n) lock_cnt <= 5'h00;
    else if (lock_cnt != 5'h1f) lock_cnt <= lock_cnt + 5'h01;
    if (!aresetn || hold_n) hold_cnt <= 5'h00;
    else if (hold_cnt != 5'h1f) hold_cnt <= hold_cnt + 5'h01;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_print_pulse; print_start |=> !print_start; endproperty
  a_print_pulse: assert property (p_print_pulse)
    else $error("print pulse too long");
  property p_hrst_pulse; hard_reset_req |=> !hard_reset_req; endproperty
  a_hrst_pulse: assert property (p_hrst_pulse)
    else $error("hard reset pulse too long");
  property p_lock_nv; lock_cnt > 5'd12 |-> !nv_write_en; endproperty
  a_lock_nv: assert property (p_lock_nv)
    else $error("storage write while locked");
  property p_lock_menu;
    lock_cnt > 5'd12 && !setup_mode |=> !setup_mode;
  endproperty
  a_lock_menu: assert property (p_lock_menu)
    else $error("setup entered while locked");
  property p_hold_freeze;
    hold_cnt > 5'd12 && peak_sel_n && valley_sel_n && ext_reset_n
      |=> $stable(display_value);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("display moved during hold");
  property p_b_answer; s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response missing");
  property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data missing");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data dropped");
  c_print: cover property (print_start);
  c_hrst: cover property (hard_reset_req);
  c_setup: cover property ($rose(setup_mode));
endmodule // mci_assertions

/* tb/mci_contacts.sv */
// Contact switch model with bounce, lines pulled up while open
`timescale 1ns/10ps
module mci_contacts (
  input wire       aclk,
  input wire [6:0] close,
  output reg [6:0] pins_n
);
  reg [6:0] last = 7'h00;
  reg [6:0] chg  = 7'h00;
  reg [1:0] bnc  = 2'h0;
  initial pins_n = 7'h7f;
  // Changed lines chatter for a few cycles so the debouncer has work
  always @(posedge aclk) begin
    last <= close;
    if (close != last) begin
      chg <= close ^ last;
      bnc <= 2'h3;
    end else if (bnc != 2'h0) bnc <= bnc - 2'h1;
    pins_n <= (bnc != 2'h0) ? (pins_n ^ chg) : ~last;
  end
endmodule // mci_contacts

/* tb/mci_meter_ctrl_tb.sv */
// Self-checking bench for the meter control block
`timescale 1ns/10ps
`include "mci_consts.vh"
module mci_meter_ctrl_tb;
  reg aclk = 1'b0, aresetn = 1'b0, reading_valid = 1'b0;
  reg [6:0] close = 7'h00;
  wire [6:0] pin_n;
  reg [23:0] reading = 24'h000032;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire tare_n = pin_n[0], peak_sel_n = pin_n[1], valley_sel_n = pin_n[2];
  wire ext_reset_n = pin_n[3], hold_n = pin_n[4], lockout_n = pin_n[5];
  wire print_reset_n = pin_n[6];
  wire setpoint_out_one, setpoint_out_two, alarm_out_one, alarm_out_two;
  wire [3:0] sp_o = {setpoint_out_one, setpoint_out_two, alarm_out_one,
    alarm_out_two};
  wire [23:0] display_value;
  wire [3:0] display_msg;
  wire display_blank, print_start, hard_reset_req, nv_write_en, setup_mode;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_errors = 0, total_checks = 0, cyc = 0, n_pr = 0, n_hr = 0, nb, i;
  logic [11:0] r_in [11] = '{12'h001, 12'h802, 12'h804, 12'h008, 12'h010,
    12'h020, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400};
  logic [3:0] r_msg [11] = '{`MCI_MSG_OVLD, `MCI_MSG_POPEN, `MCI_MSG_NOPEN,
    `MCI_MSG_IOVSC, `MCI_MSG_ROVSC, `MCI_MSG_CBOVF, `MCI_MSG_UOMOVF,
    `MCI_MSG_ERR01, `MCI_MSG_ERR02, `MCI_MSG_STORED, `MCI_MSG_NOSTOR};
  mci_meter_ctrl #(.DEB_CYC(4), .MSG_CYC(20), .FLASH_CYC(4)) u_dut (.*);
  mci_contacts u_sw (.aclk(aclk), .close(close), .pins_n(pin_n));
  always #4 aclk = ~aclk;
  // ----------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (print_start === 1'b1) n_pr <= n_pr + 1;
    if (hard_reset_req === 1'b1) n_hr <= n_hr + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task sw(input [6:0] c);
    close <= c;
    wt(16);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge aclk);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    wt(5);
    aresetn <= 1'b1;
    reading_valid <= 1'b1;
    wt(1);
    rd(8'h40, 32'h0, 2'b10);
    for (i = 0; i < 11; i++) begin
      wr(`MCI_OFF_ERRIN, {20'h0, r_in[i]}, 2'b00);
      wt(3);
      chk("msg", {28'h0, r_msg[i]}, {28'h0, display_msg});
      wr(`MCI_OFF_ERRIN, 32'h0, 2'b00);
      wt(30);
    end
    reading <= 24'h00012c;
    wt(4);
    reading <= 24'hfffffb;
    wt(4);
    reading <= 24'h000014;
    sw(7'h02);
    nb = 0;
    repeat (12) @(posedge aclk) nb = nb + display_blank;
    chk("peak", 32'h12c, {8'h0, display_value});
    chk("flash", 32'h1, {31'h0, nb > 0 && nb < 12});
    sw(7'h04);
    chk("valley", 32'hfffffb, {8'h0, display_value});
    sw(7'h00);
    sw(7'h10);
    reading <= 24'h000190;
    wt(8);
    chk("hold", 32'h14, {8'h0, display_value});
    rd(`MCI_OFF_PEAK, 32'h190, 2'b00);
    reading <= 24'h000014;
    sw(7'h00);
    wr(`MCI_OFF_CTRL, 32'h1, 2'b00);
    sw(7'h08);
    sw(7'h00);
    chk("soft reset", 32'h0, n_hr);
    wr(`MCI_OFF_CTRL, 32'h0, 2'b00);
    sw(7'h08);
    chk("hard reset", 32'h1, n_hr);
    chk("reset msg", {28'h0, `MCI_MSG_HRESET}, {28'h0, display_msg});
    sw(7'h00);
    wr(`MCI_OFF_CTRL, 32'h2, 2'b00);
    sw(7'h40);
    sw(7'h00);
    chk("print", 32'h1, n_pr);
    wr(`MCI_OFF_CTRL, 32'h0, 2'b00);
    sw(7'h40);
    sw(7'h00);
    chk("no print", 32'h1, n_pr);
    sw(7'h20);
    wr(`MCI_OFF_CTRL, 32'h8, 2'b10);
    wt(4);
    chk("locked menu", 32'h0, {31'h0, setup_mode});
    sw(7'h00);
    wr(`MCI_OFF_CTRL, 32'h8, 2'b00);
    wt(4);
    chk("menu", 32'h1, {31'h0, setup_mode});
    wr(`MCI_OFF_CTRL, 32'h14, 2'b00);
    reading <= 24'h000064;
    sw(7'h01);
    sw(7'h00);
    rd(`MCI_OFF_TARE, 32'h64, 2'b00);
    chk("tared", 32'h0, {8'h0, display_value});
    sw(7'h40);
    sw(7'h00);
    chk("alarms", 32'h0, {28'h0, sp_o});
    wr(`MCI_OFF_SETPT, 32'hffffff, 2'b00);
    chk("setpoint", 32'h8, {28'h0, sp_o});
    reading <= 24'h0f42a4;
    wt(8);
    chk("nines", {28'h0, `MCI_MSG_NINES}, {28'h0, display_msg});
    wrap_up;
  end
endmodule // mci_meter_ctrl_tb
bind mci_meter_ctrl mci_assertions u_chk (.*);
